// [hdl/febk_cfg.svh]
// register offsets, reset values and field positions of the fault flag bank
`ifndef FEBK_CFG_SVH
`define FEBK_CFG_SVH
`define FEBK_OFS_SUPPLY_THERMAL 8'h52
`define FEBK_OFS_SERIAL_ERROR 8'h53
`define FEBK_OFS_BUS_FAULT 8'h54
`define FEBK_OFS_MASK_ONE 8'h56
`define FEBK_OFS_MASK_TWO 8'h57
`define FEBK_OFS_MASK_THREE 8'h58
`define FEBK_RST_SUPPLY_THERMAL 8'h40
`define FEBK_RST_SERIAL_ERROR 8'h00
`define FEBK_RST_BUS_FAULT 8'h00
`define FEBK_RST_MASK_ONE 8'hF3
`define FEBK_RST_MASK_TWO 8'h3F
`define FEBK_RST_MASK_THREE 8'h80
`define FEBK_BIT_POWER_UP 6
`define FEBK_BIT_REG_OVER 5
`define FEBK_BIT_SUPPLY_UNDER 4
`define FEBK_BIT_REG_UNDER 2
`define FEBK_BIT_THERM_TRIP 1
`define FEBK_BIT_THERM_WARN 0
`define FEBK_BIT_SERIAL_ERR 7
`define FEBK_BIT_LINES_SHORT 5
`define FEBK_BIT_HIGH_BAT 4
`define FEBK_BIT_LOW_GND 3
`define FEBK_BIT_BUS_OPEN 2
`define FEBK_BIT_BUS_GND 1
`define FEBK_BIT_BUS_BAT 0
`define FEBK_MSK_SUPPLY_THERMAL 8'h77
`define FEBK_MSK_SERIAL_ERROR 8'h80
`define FEBK_MSK_BUS_FAULT 8'h3F
`define FEBK_MSK_MASK_ONE 8'hF5
`define FEBK_MSK_MASK_TWO 8'h37
`define FEBK_MSK_MASK_THREE 8'h80
`endif

// [hdl/febk_pkg.sv]
// types shared by the fault flag bank
package febk_pkg;
  typedef logic [7:0] febk_byte_type;
endpackage

// [hdl/febk_fault_event_flag_bank.sv]
// fault flag and mask bank of the register port
`timescale 1ns/1ps
`default_nettype none
`include "febk_cfg.svh"
module febk_fault_event_flag_bank
  import febk_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic regulator_over_evt,
  input wire logic supply_under_evt,
  input wire logic regulator_under_evt,
  input wire logic thermal_trip_evt,
  input wire logic thermal_warn_evt,
  input wire logic serial_status_error,
  input wire logic bus_lines_shorted_evt,
  input wire logic high_line_battery_evt,
  input wire logic low_line_ground_evt,
  input wire logic bus_open_evt,
  input wire logic bus_ground_short_evt,
  input wire logic bus_battery_short_evt,
  input wire logic [7:0] event_flags_one,
  output logic global_error_summary,
  output logic irq_request
);
  febk_byte_type supply_thermal_flags_r, supply_thermal_flags_nxt;
  febk_byte_type serial_error_flags_r, serial_error_flags_nxt;
  febk_byte_type bus_fault_flags_r, bus_fault_flags_nxt;
  febk_byte_type event_mask_one_r, event_mask_one_nxt;
  febk_byte_type event_mask_two_r, event_mask_two_nxt;
  febk_byte_type event_mask_three_r, event_mask_three_nxt;
  febk_byte_type reg_rdata_nxt;
  logic serial_status_d_r;
  febk_byte_type st_set, bus_set, se_set, st_clr, se_clr, bus_clr;
  logic wr_st, wr_se, wr_bus;
  logic global_error_summary_nxt, irq_request_nxt;

  assign wr_st = reg_wr && (reg_addr == `FEBK_OFS_SUPPLY_THERMAL);
  assign wr_se = reg_wr && (reg_addr == `FEBK_OFS_SERIAL_ERROR);
  assign wr_bus = reg_wr && (reg_addr == `FEBK_OFS_BUS_FAULT);

  always_comb begin
    st_set = 8'h00;
    st_set[`FEBK_BIT_REG_OVER] = regulator_over_evt;
    st_set[`FEBK_BIT_SUPPLY_UNDER] = supply_under_evt;
    st_set[`FEBK_BIT_REG_UNDER] = regulator_under_evt;
    st_set[`FEBK_BIT_THERM_TRIP] = thermal_trip_evt;
    st_set[`FEBK_BIT_THERM_WARN] = thermal_warn_evt;
    se_set = 8'h00;
    // rising edge only: a status error that stays set must not re-arm a cleared flag
    se_set[`FEBK_BIT_SERIAL_ERR] = serial_status_error && !serial_status_d_r;
    bus_set = 8'h00;
    bus_set[`FEBK_BIT_LINES_SHORT] = bus_lines_shorted_evt;
    bus_set[`FEBK_BIT_HIGH_BAT] = high_line_battery_evt;
    bus_set[`FEBK_BIT_LOW_GND] = low_line_ground_evt;
    bus_set[`FEBK_BIT_BUS_OPEN] = bus_open_evt;
    bus_set[`FEBK_BIT_BUS_GND] = bus_ground_short_evt;
    bus_set[`FEBK_BIT_BUS_BAT] = bus_battery_short_evt;
    st_clr = wr_st ? reg_wdata : 8'h00;
    se_clr = wr_se ? reg_wdata : 8'h00;
    bus_clr = wr_bus ? reg_wdata : 8'h00;
    // set wins over a clear in the same cycle; reserved bits masked away
    supply_thermal_flags_nxt = ((supply_thermal_flags_r & ~st_clr) | st_set) & `FEBK_MSK_SUPPLY_THERMAL;
    serial_error_flags_nxt = ((serial_error_flags_r & ~se_clr) | se_set) & `FEBK_MSK_SERIAL_ERROR;
    bus_fault_flags_nxt = ((bus_fault_flags_r & ~bus_clr) | bus_set) & `FEBK_MSK_BUS_FAULT;
    event_mask_one_nxt = event_mask_one_r;
    event_mask_two_nxt = event_mask_two_r;
    event_mask_three_nxt = event_mask_three_r;
    if (reg_wr) begin
      unique case (reg_addr)
        `FEBK_OFS_MASK_ONE: event_mask_one_nxt = reg_wdata & `FEBK_MSK_MASK_ONE;
        `FEBK_OFS_MASK_TWO: event_mask_two_nxt = reg_wdata & `FEBK_MSK_MASK_TWO;
        `FEBK_OFS_MASK_THREE: event_mask_three_nxt = reg_wdata & `FEBK_MSK_MASK_THREE;
        default: ;
      endcase
    end
    reg_rdata_nxt = reg_rdata;
    if (reg_rd) begin
      unique case (reg_addr)
        `FEBK_OFS_SUPPLY_THERMAL: reg_rdata_nxt = supply_thermal_flags_r;
        `FEBK_OFS_SERIAL_ERROR: reg_rdata_nxt = serial_error_flags_r;
        `FEBK_OFS_BUS_FAULT: reg_rdata_nxt = bus_fault_flags_r;
        `FEBK_OFS_MASK_ONE: reg_rdata_nxt = event_mask_one_r;
        `FEBK_OFS_MASK_TWO: reg_rdata_nxt = event_mask_two_r;
        `FEBK_OFS_MASK_THREE: reg_rdata_nxt = event_mask_three_r;
        default: reg_rdata_nxt = 8'h00;
      endcase
    end
    // summary ignores masks, so it flags even disabled faults
    global_error_summary_nxt = |{event_flags_one, supply_thermal_flags_nxt, serial_error_flags_nxt,
                                 bus_fault_flags_nxt};
    // next-state terms keep both outputs aligned with the flag registers
    irq_request_nxt = |{event_flags_one & event_mask_one_nxt, supply_thermal_flags_nxt & event_mask_two_nxt,
                        serial_error_flags_nxt & event_mask_three_nxt, bus_fault_flags_nxt};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      supply_thermal_flags_r <= `FEBK_RST_SUPPLY_THERMAL;
      serial_error_flags_r <= `FEBK_RST_SERIAL_ERROR;
      bus_fault_flags_r <= `FEBK_RST_BUS_FAULT;
      event_mask_one_r <= `FEBK_RST_MASK_ONE;
      event_mask_two_r <= `FEBK_RST_MASK_TWO;
      event_mask_three_r <= `FEBK_RST_MASK_THREE;
      serial_status_d_r <= 1'b0;
      reg_rdata <= 8'h00;
      global_error_summary <= 1'b0;
      irq_request <= 1'b0;
    end else begin
      supply_thermal_flags_r <= supply_thermal_flags_nxt;
      serial_error_flags_r <= serial_error_flags_nxt;
      bus_fault_flags_r <= bus_fault_flags_nxt;
      event_mask_one_r <= event_mask_one_nxt;
      event_mask_two_r <= event_mask_two_nxt;
      event_mask_three_r <= event_mask_three_nxt;
      serial_status_d_r <= serial_status_error;
      reg_rdata <= reg_rdata_nxt;
      global_error_summary <= global_error_summary_nxt;
      irq_request <= irq_request_nxt;
    end
  end

  // power-up flag: set by reset, only a written one removes it
  a_power_up_reset: assert property (
    @(posedge clk) $fell(rst) |-> supply_thermal_flags_r[`FEBK_BIT_POWER_UP])
    else $error("power-up flag not set after reset");
  a_power_up_hold: assert property (
    @(posedge clk) disable iff (rst)
    $fell(supply_thermal_flags_r[`FEBK_BIT_POWER_UP]) |->
    $past(wr_st) && $past(reg_wdata[`FEBK_BIT_POWER_UP]))
    else $error("power-up flag cleared without write");
  // a fault must show at the edge after its condition, even under a clear
  a_reg_over_latch: assert property (
    @(posedge clk) disable iff (rst)
    regulator_over_evt |=> supply_thermal_flags_r[`FEBK_BIT_REG_OVER])
    else $error("regulator over not latched");
  a_supply_under_latch: assert property (
    @(posedge clk) disable iff (rst)
    supply_under_evt |=> supply_thermal_flags_r[`FEBK_BIT_SUPPLY_UNDER])
    else $error("supply under not latched");
  a_reg_under_latch: assert property (
    @(posedge clk) disable iff (rst)
    regulator_under_evt |=> supply_thermal_flags_r[`FEBK_BIT_REG_UNDER])
    else $error("regulator under not latched");
  a_reg_over_clear: assert property (
    @(posedge clk) disable iff (rst)
    wr_st && reg_wdata[`FEBK_BIT_REG_OVER] && !regulator_over_evt |=>
    !supply_thermal_flags_r[`FEBK_BIT_REG_OVER])
    else $error("regulator over flag not cleared by write");
  a_thermal_latch: assert property (
    @(posedge clk) disable iff (rst)
    thermal_trip_evt && !thermal_warn_evt && !wr_st ##1 !thermal_trip_evt && !wr_st |=>
    supply_thermal_flags_r[`FEBK_BIT_THERM_TRIP])
    else $error("thermal trip not held");
  a_warn_latch: assert property (
    @(posedge clk) disable iff (rst)
    thermal_warn_evt |=> supply_thermal_flags_r[`FEBK_BIT_THERM_WARN])
    else $error("thermal warning not latched");
  a_serial_err_set: assert property (
    @(posedge clk) disable iff (rst)
    $rose(serial_status_error) && !$past(rst) |=> serial_error_flags_r[`FEBK_BIT_SERIAL_ERR])
    else $error("serial error flag not set");
  // a status error held high must not re-arm the flag after software clears it
  a_serial_no_rearm: assert property (
    @(posedge clk) disable iff (rst)
    wr_se && reg_wdata[`FEBK_BIT_SERIAL_ERR] && serial_status_error && $past(serial_status_error) &&
    !$past(rst) |=> !serial_error_flags_r[`FEBK_BIT_SERIAL_ERR])
    else $error("serial error flag re-armed by held status");
  a_bus_short_latch: assert property (
    @(posedge clk) disable iff (rst)
    bus_lines_shorted_evt |=> bus_fault_flags_r[`FEBK_BIT_LINES_SHORT])
    else $error("bus short not latched");
  a_high_bat_latch: assert property (
    @(posedge clk) disable iff (rst)
    high_line_battery_evt |=> bus_fault_flags_r[`FEBK_BIT_HIGH_BAT])
    else $error("high line battery short not latched");
  a_low_gnd_latch: assert property (
    @(posedge clk) disable iff (rst)
    low_line_ground_evt |=> bus_fault_flags_r[`FEBK_BIT_LOW_GND])
    else $error("low line ground short not latched");
  a_bus_open_latch: assert property (
    @(posedge clk) disable iff (rst)
    bus_open_evt |=> bus_fault_flags_r[`FEBK_BIT_BUS_OPEN])
    else $error("bus open not latched");
  a_bus_gnd_latch: assert property (
    @(posedge clk) disable iff (rst)
    bus_ground_short_evt |=> bus_fault_flags_r[`FEBK_BIT_BUS_GND])
    else $error("ground short not latched");
  a_bus_gnd_hold: assert property (
    @(posedge clk) disable iff (rst)
    $fell(bus_fault_flags_r[`FEBK_BIT_BUS_GND]) |->
    $past(wr_bus) && $past(reg_wdata[`FEBK_BIT_BUS_GND]))
    else $error("ground short flag cleared without write");
  a_bus_bat_latch: assert property (
    @(posedge clk) disable iff (rst)
    bus_battery_short_evt |=> bus_fault_flags_r[`FEBK_BIT_BUS_BAT])
    else $error("battery short not latched");
  a_bus_bat_hold: assert property (
    @(posedge clk) disable iff (rst)
    $fell(bus_fault_flags_r[`FEBK_BIT_BUS_BAT]) |->
    $past(wr_bus) && $past(reg_wdata[`FEBK_BIT_BUS_BAT]))
    else $error("battery short flag cleared without write");
  a_bus_rsvd_zero: assert property (
    @(posedge clk) disable iff (rst) bus_fault_flags_r[7:6] == 2'b00)
    else $error("bus fault reserved bits nonzero");
  a_bus_rsvd_read: assert property (
    @(posedge clk) disable iff (rst)
    reg_rd && (reg_addr == `FEBK_OFS_BUS_FAULT) |=> reg_rdata[7:6] == 2'b00)
    else $error("bus fault reserved bits read nonzero");
  // masks keep only their writable bits
  a_mask_one_write: assert property (
    @(posedge clk) disable iff (rst)
    reg_wr && (reg_addr == `FEBK_OFS_MASK_ONE) |=>
    event_mask_one_r == ($past(reg_wdata) & `FEBK_MSK_MASK_ONE))
    else $error("mask one write not taken");
  a_mask_two_write: assert property (
    @(posedge clk) disable iff (rst)
    reg_wr && (reg_addr == `FEBK_OFS_MASK_TWO) |=>
    event_mask_two_r == ($past(reg_wdata) & `FEBK_MSK_MASK_TWO))
    else $error("mask two write not taken");
  a_mask_three_write: assert property (
    @(posedge clk) disable iff (rst)
    reg_wr && (reg_addr == `FEBK_OFS_MASK_THREE) |=>
    event_mask_three_r == ($past(reg_wdata) & `FEBK_MSK_MASK_THREE))
    else $error("mask three write not taken");
  a_mask_three_rsvd: assert property (
    @(posedge clk) disable iff (rst) event_mask_three_r[6:0] == 7'h00)
    else $error("mask three reserved bits nonzero");
  // first edge after reset still shows the reset value of the summary
  a_summary_or: assert property (
    @(posedge clk) disable iff (rst)
    !$past(rst) |-> global_error_summary ==
    |{$past(event_flags_one), supply_thermal_flags_r, serial_error_flags_r, bus_fault_flags_r})
    else $error("summary differs from flag OR");
  a_irq_in_summary: assert property (
    @(posedge clk) disable iff (rst) irq_request |-> global_error_summary)
    else $error("irq without summary");
  a_masked_no_irq: assert property (
    @(posedge clk) disable iff (rst)
    (event_mask_two_r == 8'h00) && (event_mask_three_r == 8'h00) && ($past(event_flags_one) == 8'h00)
    && (bus_fault_flags_r == 8'h00) |-> !irq_request)
    else $error("irq with all sources masked");
  // bus faults carry no enable here, so any of them must reach the host
  a_bus_irq: assert property (
    @(posedge clk) disable iff (rst)
    bus_fault_flags_r != 8'h00 |-> irq_request)
    else $error("bus fault did not raise irq");
endmodule
`default_nettype wire

// [bench/febk_host_model.sv]
// host side model driving the register port strobes
`timescale 1ns/1ps
`default_nettype none
module febk_host_model (
  input wire logic clk,
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0,
  output logic [7:0] reg_addr = 8'h00,
  output logic [7:0] reg_wdata = 8'h00,
  input wire logic [7:0] reg_rdata
);
  // entered just after an edge; held to the taking edge, then one idle edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    reg_wdata = ~d;
    @(posedge clk);
    #1;
  endtask
  // data is registered at the read edge and stands until the next read
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    @(posedge clk);
    #1;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// [bench/febk_fault_event_flag_bank_test.sv]
// self-checking bench for the fault flag bank
`timescale 1ns/1ps
`default_nettype none
module febk_fault_event_flag_bank_test;
  import febk_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr, reg_rd, sum, irq;
  logic [7:0] addr, wdata, rdata, got;
  logic [7:0] efo = 8'h00;
  logic [11:0] ev = 12'h000;
  febk_byte_type m [0:6];
  febk_byte_type wmsk [0:6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hF5, 8'h37, 8'h80};
  int ereg [0:11] = '{0, 0, 0, 0, 0, 1, 2, 2, 2, 2, 2, 2};
  int ebit [0:11] = '{5, 4, 2, 1, 0, 7, 5, 4, 3, 2, 1, 0};
  int num_errors = 0;
  int num_checks = 0;
  int seed = 32'h93fc;
  always #20 clk = ~clk;
  febk_host_model u_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(addr), .reg_wdata(wdata),
    .reg_rdata(rdata));
  febk_fault_event_flag_bank u_dut (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(addr),
    .reg_wdata(wdata), .reg_rdata(rdata), .regulator_over_evt(ev[0]), .supply_under_evt(ev[1]),
    .regulator_under_evt(ev[2]), .thermal_trip_evt(ev[3]), .thermal_warn_evt(ev[4]), .serial_status_error(ev[5]),
    .bus_lines_shorted_evt(ev[6]), .high_line_battery_evt(ev[7]), .low_line_ground_evt(ev[8]),
    .bus_open_evt(ev[9]), .bus_ground_short_evt(ev[10]), .bus_battery_short_evt(ev[11]),
    .event_flags_one(efo), .global_error_summary(sum), .irq_request(irq));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic outs();
    chk("summary", {7'h00, |{m[0], m[1], m[2], efo}}, {7'h00, sum});
    chk("irq", {7'h00, |{m[0] & m[5], m[1] & m[6], m[2], efo & m[4]}}, {7'h00, irq});
  endtask
  task automatic rdc(input int i);
    u_host.rd(8'h52 + i[7:0], got);
    chk("read", m[i], got);
  endtask
  // flags clear on ones, masks keep only their writable bits, 55h holds nothing
  task automatic wrm(input int i, input logic [7:0] d);
    u_host.wr(8'h52 + i[7:0], d);
    m[i] = (i < 3) ? (m[i] & ~d) : (d & wmsk[i]);
  endtask
  task automatic do_reset();
    rst = 1'b1;
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    m = '{8'h40, 8'h00, 8'h00, 8'h00, 8'hF3, 8'h3F, 8'h80};
    for (int i = 0; i < 7; i++) rdc(i);
    outs();
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #3000000 num_errors++;
    final_report();
  end
  initial begin
    efo = 8'($random(seed));
    do_reset();
    for (int i = 3; i < 7; i++) wrm(i, 8'($random(seed)));
    for (int i = 0; i < 7; i++) rdc(i);
    wrm(0, 8'hBF);
    rdc(0);
    wrm(0, 8'h40);
    rdc(0);
    outs();
    for (int k = 0; k < 12; k++) begin
      ev[k] = 1'b1;
      @(posedge clk);
      #1 ev[k] = 1'b0;
      m[ereg[k]][ebit[k]] = 1'b1;
      outs();
      wrm(2, 8'hC0);
      wrm(ereg[k], ~(8'h01 << ebit[k]));
      rdc(ereg[k]);
      wrm(ereg[k], 8'h01 << ebit[k]);
      rdc(ereg[k]);
      outs();
      wrm(5, 8'($random(seed)));
      wrm(6, 8'($random(seed)));
      outs();
    end
    // a fault in the cycle of its own clear must survive the write
    ev[0] = 1'b1;
    u_host.wr(8'h52, 8'h20);
    ev[0] = 1'b0;
    m[0][5] = 1'b1;
    rdc(0);
    wrm(0, 8'h20);
    rdc(0);
    // enables two and three cleared, efo zeroed: the fault still latches but stays off the interrupt
    efo = 8'h00;
    wrm(5, 8'h00);
    wrm(6, 8'h00);
    ev[3] = 1'b1;
    @(posedge clk);
    #1 ev[3] = 1'b0;
    m[0][1] = 1'b1;
    outs();
    rdc(0);
    wrm(0, 8'h02);
    outs();
    // a level held high must not set the serial flag again after a clear
    ev[5] = 1'b1;
    @(posedge clk);
    #1 m[1] = 8'h80;
    wrm(1, 8'h80);
    rdc(1);
    outs();
    ev[5] = 1'b0;
    do_reset();
    final_report();
  end
endmodule
`default_nettype wire
